/* irq_timer_consts.vh */
`ifndef IRQ_TIMER_CONSTS_VH
`define IRQ_TIMER_CONSTS_VH
// Register byte offsets (index times four)
`define IDX_TIMER_MODE    6'h06
`define REG_TIMER_MODE    {`IDX_TIMER_MODE, 2'b00}
`define REG_REQ_FLAGS     8'h00
`define REG_LINE_ENABLE   8'h04
`define REG_EDGE_SELECT   8'h08
`define REG_GLOBAL_CTRL   8'h0c
`define REG_COUNT         8'h10
`define REG_STACK_PTR     8'h14
`define REG_STATUS        8'h1c
`define REG_SAVED_AF      8'h20
// Timer mode field positions
`define SRC_HI            7
`define SRC_LO            5
`define PRE_HI            4
`define PRE_LO            3
`define TAP_HI            2
`define TAP_LO            0
// Clock source codes
`define SRC_STOP          3'h0
`define SRC_SYSTEM        3'h1
`define SRC_PIN_A4        3'h3
`define SRC_FAST_RC       3'h4
`define SRC_SLOW_RC       3'h6
`define SRC_PIN_A0        3'h7
// Request line positions and timer edge select bit
`define LINE_PIN          0
`define LINE_SIXTEEN_BIT_TIMER      2
`define TIMER_EDGE_BIT    4
// Fixed vector and stack step
`define VECTOR_ADDR       16'h0010
`define STACK_STEP        8'h02
// Reset values
`define RST_TIMER_MODE    8'h00
`define RST_EDGE_SELECT   8'h00
`define RST_STACK_PTR     8'h00
`endif

/* sixteen_bit_timer_interrupt_controller.v */
`timescale 1ns/100ps
`include "irq_timer_consts.vh"

// Contract
// - Mode bits 7:5 choose timer clock source; code zero stops counting
// - Mode bits 4:3 prescale the selected clock by 1, 4, 16 or 64
// - Mode bits 2:0 pick counter bit 8 to 15 as timer request
// - Counter is sixteen bits and counts only upward per prescaled tick
// - Store loads counter from memory; load copies count back to memory
// - Edge register bit 4 picks rising or falling tap transition
// - Timer request sets request flag bit 2
// - Six request lines: pin, sixteen_bit_timer, timer2, timer3, comparator, pwm
// - Each line has an enable; only enabled lines may be taken
// - Flags set only by hardware; writing zero clears a flag
// - Edge register selects rising, falling or both for the pin and comparator sources
// - Global enable and disable instructions gate all request lines
// - Flags still set while their line enable is clear
// - Entry pushes program counter at stack pointer, then adds two
// - Entry clears the global enable automatically
// - After entry, fetch resumes at vector 0x010
// - Return subtracts two, then pops program counter and sets global enable
// - Push stores accumulator and flags; pop restores both
// - Reading request flags shows pending sources during service
// - Comparator output raises a request and reads as status
module sixteen_bit_timer_interrupt_controller #(
  parameter LINES = 6
) (
  input  wire        aclk,           // System clock, 40 MHz
  input  wire        aresetn,        // Synchronous reset, active low
  input  wire [7:0]  s_axi_awaddr,   // Write address
  input  wire        s_axi_awvalid,  // Write address valid
  output reg         s_axi_awready,  // Write address ready
  input  wire [31:0] s_axi_wdata,    // Write data
  input  wire [3:0]  s_axi_wstrb,    // Write strobes
  input  wire        s_axi_wvalid,   // Write data valid
  output reg         s_axi_wready,   // Write data ready
  output reg  [1:0]  s_axi_bresp,    // Write response
  output reg         s_axi_bvalid,   // Write response valid
  input  wire        s_axi_bready,   // Write response ready
  input  wire [7:0]  s_axi_araddr,   // Read address
  input  wire        s_axi_arvalid,  // Read address valid
  output reg         s_axi_arready,  // Read address ready
  output reg  [31:0] s_axi_rdata,    // Read data
  output reg  [1:0]  s_axi_rresp,    // Read response
  output reg         s_axi_rvalid,   // Read data valid
  input  wire        s_axi_rready,   // Read data ready
  input  wire        pin_a0_clock,   // Pin PA0 level, async
  input  wire        pin_a4_clock,   // Pin PA4 level, async
  input  wire        fast_rc_oscillator, // Fast RC level, async
  input  wire        slow_rc_oscillator, // Slow RC level, async
  input  wire        pin_a5_level,   // Pin PA5 level, async
  input  wire        pin_select_a5,  // Use PA5 instead of PA0 for pin line
  input  wire        timer2_event,   // Timer2 request pulse
  input  wire        timer3_event,   // Timer3 request pulse
  input  wire        comparator_source, // Comparator output level
  input  wire        pwm_generator_source, // PWM group request pulse
  input  wire        boundary,       // Instruction boundary pulse from core
  input  wire        retire_return,  // Return-from-interrupt executes
  input  wire        global_on,      // Global-enable instruction
  input  wire        global_off,     // Global-disable instruction
  input  wire        store_to_timer, // Store-to-timer instruction
  input  wire        load_from_timer,// Load-from-timer instruction
  input  wire        push_af,        // Push accumulator and flags
  input  wire        pop_af,         // Pop accumulator and flags
  input  wire [15:0] mem_rdata,      // Data word read from memory
  input  wire [15:0] program_counter,// Current program counter
  input  wire [7:0]  accumulator,    // Accumulator value
  input  wire [7:0]  flag_register,  // Flag register value
  output reg         mem_we,         // Data memory write strobe
  output reg  [7:0]  mem_addr,       // Data memory address
  output reg  [15:0] mem_wdata,      // Data memory write word
  output reg         pc_load,        // Program counter load strobe
  output reg  [15:0] pc_value,       // New program counter value
  output reg         af_restore,     // Accumulator and flags restore strobe
  output reg  [15:0] af_value,       // Restored accumulator and flags
  output reg         irq_taken       // Interrupt entry pulse
);

  reg [7:0]        timer_mode_register;
  reg [LINES-1:0]  req_flags;
  reg [LINES-1:0]  line_enable_register;
  reg [7:0]        edge_select;
  reg              global_enable;
  reg [15:0]       count;
  reg [7:0]        stack_pointer;
  reg [5:0]        prescale;
  reg [2:0]        s_a0, s_a4, s_fr, s_sr, s_a5, s_cmp;
  reg              src_prev;
  reg              tap_prev;
  reg              pin_prev;
  reg              cmp_prev;
  reg              pop_pending;
  reg              pop_af_pending;
  reg [7:0]        aw_addr;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;
  reg              aw_have;
  reg              w_have;
  reg [LINES-1:0]  hw_set;
  reg [LINES-1:0]  sw_clear;
  reg              src_level;
  reg              tick;
  reg              div_hit;
  reg              tap;
  reg              pin_now;
  reg              pin_edge;
  reg              cmp_edge;
  reg [31:0]       next_rdata;
  reg              rd_ok;
  wire             wr_go;
  wire [2:0]       src_code;
  wire [1:0]       pre_code;

  assign src_code = timer_mode_register[`SRC_HI:`SRC_LO];
  assign pre_code = timer_mode_register[`PRE_HI:`PRE_LO];
  assign wr_go    = aw_have && w_have && !s_axi_bvalid;

  // Three-stage synchronisers; stage 0 feeds only stage 1
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_a0  <= 3'h0;
      s_a4  <= 3'h0;
      s_fr  <= 3'h0;
      s_sr  <= 3'h0;
      s_a5  <= 3'h0;
      s_cmp <= 3'h0;
    end
    else
    begin
      s_a0  <= {s_a0[1:0], pin_a0_clock};
      s_a4  <= {s_a4[1:0], pin_a4_clock};
      s_fr  <= {s_fr[1:0], fast_rc_oscillator};
      s_sr  <= {s_sr[1:0], slow_rc_oscillator};
      s_a5  <= {s_a5[1:0], pin_a5_level};
      s_cmp <= {s_cmp[1:0], comparator_source};
    end
  end

  // Source select and prescaler tick; external sources sampled on aclk,
  // so they must run well below 20 MHz to be counted faithfully
  always @*
  begin
    case (src_code)
      `SRC_PIN_A4:  src_level = s_a4[1] & s_a4[2];
      `SRC_FAST_RC: src_level = s_fr[1] & s_fr[2];
      `SRC_SLOW_RC: src_level = s_sr[1] & s_sr[2];
      `SRC_PIN_A0:  src_level = s_a0[1] & s_a0[2];
      default:      src_level = 1'b0;
    endcase
    case (src_code)
      `SRC_STOP:   tick = 1'b0;
      `SRC_SYSTEM: tick = 1'b1;
      `SRC_PIN_A4, `SRC_FAST_RC, `SRC_SLOW_RC, `SRC_PIN_A0:
        tick = (s_a0[1] == s_a0[2] || src_code != `SRC_PIN_A0) &&
               src_level && !src_prev;
      default:     tick = 1'b0;
    endcase
    case (pre_code)
      2'h0:    div_hit = 1'b1;
      2'h1:    div_hit = (prescale[1:0] == 2'h3);
      2'h2:    div_hit = (prescale[3:0] == 4'hf);
      default: div_hit = (prescale == 6'h3f);
    endcase
    tap     = count[{1'b1, timer_mode_register[`TAP_HI:`TAP_LO]}];
    pin_now = pin_select_a5 ? (s_a5[1] & s_a5[2]) : (s_a0[1] & s_a0[2]);
  end

  // Edge detection and flag set/clear terms
  always @*
  begin
    hw_set = {LINES{1'b0}};
    pin_edge = (pin_now != pin_prev) &&
               (edge_select[1:0] == 2'h0 ||
                (edge_select[1:0] == 2'h1 && pin_now) ||
                (edge_select[1:0] == 2'h2 && !pin_now));
    cmp_edge = (s_cmp[2] != cmp_prev) &&
               (edge_select[7:6] == 2'h0 ||
                (edge_select[7:6] == 2'h1 && s_cmp[2]) ||
                (edge_select[7:6] == 2'h2 && !s_cmp[2]));
    hw_set[`LINE_PIN]     = pin_edge;
    hw_set[1]             = timer2_event;
    hw_set[`LINE_SIXTEEN_BIT_TIMER] = (tap != tap_prev) &&
      (edge_select[`TIMER_EDGE_BIT] ? !tap : tap);
    hw_set[3]             = timer3_event;
    hw_set[4]             = cmp_edge;
    hw_set[5]             = pwm_generator_source;
    sw_clear = {LINES{1'b0}};
    if (wr_go && aw_addr == `REG_REQ_FLAGS && w_strb[0])
      sw_clear = ~w_data[LINES-1:0];
  end

  // Per-line flags: hardware set wins over software clear
  genvar i;
  generate
    for (i = 0; i < LINES; i = i + 1)
    begin : g_flag
      always @(posedge aclk)
      begin
        if (!aresetn)
          req_flags[i] <= 1'b0;
        else if (hw_set[i])
          req_flags[i] <= 1'b1;
        else if (sw_clear[i])
          req_flags[i] <= 1'b0;
      end
    end
  endgenerate

  // Timer counter, prescaler and edge history
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count    <= 16'h0000;
      prescale <= 6'h00;
      src_prev <= 1'b0;
      tap_prev <= 1'b0;
      pin_prev <= 1'b0;
      cmp_prev <= 1'b0;
    end
    else
    begin
      src_prev <= src_level;
      tap_prev <= tap;
      pin_prev <= pin_now;
      cmp_prev <= s_cmp[2];
      if (tick)
        prescale <= prescale + 6'h01;
      if (store_to_timer)
        count <= mem_rdata;
      else if (tick && div_hit)
        count <= count + 16'h0001;
    end
  end

  // Core sequencing: entry, return, push/pop, timer load to memory
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      global_enable  <= 1'b0;
      stack_pointer  <= `RST_STACK_PTR;
      mem_we         <= 1'b0;
      mem_addr       <= 8'h00;
      mem_wdata      <= 16'h0000;
      pc_load        <= 1'b0;
      pc_value       <= 16'h0000;
      af_restore     <= 1'b0;
      af_value       <= 16'h0000;
      irq_taken      <= 1'b0;
      pop_pending    <= 1'b0;
      pop_af_pending <= 1'b0;
    end
    else
    begin
      mem_we     <= 1'b0;
      pc_load    <= 1'b0;
      af_restore <= 1'b0;
      irq_taken  <= 1'b0;
      pop_pending    <= 1'b0;
      pop_af_pending <= 1'b0;
      if (pop_pending)
      begin
        pc_value      <= mem_rdata;
        pc_load       <= 1'b1;
        global_enable <= 1'b1;
      end
      else if (pop_af_pending)
      begin
        af_value   <= mem_rdata;
        af_restore <= 1'b1;
      end
      else if (boundary && global_enable &&
               |(req_flags & line_enable_register))
      begin
        mem_addr      <= stack_pointer;
        mem_wdata     <= program_counter;
        mem_we        <= 1'b1;
        stack_pointer <= stack_pointer + `STACK_STEP;
        global_enable <= 1'b0;
        pc_value      <= `VECTOR_ADDR;
        pc_load       <= 1'b1;
        irq_taken     <= 1'b1;
      end
      else if (retire_return)
      begin
        mem_addr      <= stack_pointer - `STACK_STEP;
        stack_pointer <= stack_pointer - `STACK_STEP;
        pop_pending   <= 1'b1;
      end
      else if (push_af)
      begin
        mem_addr      <= stack_pointer;
        mem_wdata     <= {flag_register, accumulator};
        mem_we        <= 1'b1;
        stack_pointer <= stack_pointer + `STACK_STEP;
      end
      else if (pop_af)
      begin
        mem_addr       <= stack_pointer - `STACK_STEP;
        stack_pointer  <= stack_pointer - `STACK_STEP;
        pop_af_pending <= 1'b1;
      end
      else if (load_from_timer)
      begin
        mem_wdata <= count;
        mem_we    <= 1'b1;
      end
      else if (global_on)
        global_enable <= 1'b1;
      else if (global_off)
        global_enable <= 1'b0;
      if (wr_go && aw_addr == `REG_STACK_PTR && w_strb[0])
        stack_pointer <= w_data[7:0];
      if (wr_go && aw_addr == `REG_GLOBAL_CTRL && w_strb[0])
        global_enable <= w_data[0];
    end
  end

  // AXI write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      timer_mode_register  <= `RST_TIMER_MODE;
      line_enable_register <= {LINES{1'b0}};
      edge_select          <= `RST_EDGE_SELECT;
    end
    else
    begin
      s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb; // Strobes belong to the data beat
        w_have <= 1'b1;
      end
      if (wr_go)
      begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (aw_addr)
          `REG_TIMER_MODE:
            if (w_strb[0]) timer_mode_register <= w_data[7:0];
          `REG_LINE_ENABLE:
            if (w_strb[0]) line_enable_register <= w_data[LINES-1:0];
          `REG_EDGE_SELECT:
            if (w_strb[0]) edge_select <= w_data[7:0];
          `REG_REQ_FLAGS, `REG_STACK_PTR, `REG_GLOBAL_CTRL: ;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode; unmapped addresses answer SLVERR with zero data
  always @*
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `REG_TIMER_MODE:  next_rdata = {24'h0, timer_mode_register};
      `REG_REQ_FLAGS:   next_rdata = {26'h0, req_flags};
      `REG_LINE_ENABLE: next_rdata = {26'h0, line_enable_register};
      `REG_EDGE_SELECT: next_rdata = {24'h0, edge_select};
      `REG_GLOBAL_CTRL: next_rdata = {31'h0, global_enable};
      `REG_COUNT:       next_rdata = {16'h0, count};
      `REG_STACK_PTR:   next_rdata = {24'h0, stack_pointer};
      `REG_STATUS:      next_rdata = {31'h0, s_cmp[2]};
      `REG_SAVED_AF:    next_rdata = {16'h0, af_value};
      default:
      begin
        next_rdata = 32'h00000000;
        rd_ok      = 1'b0;
      end
    endcase
  end

  // AXI read channel: one read at a time, answer one cycle after address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // sixteen_bit_timer_interrupt_controller

/* cpu_core_model.sv */
`timescale 1ns/100ps
// Data memory of the core; stacked words sit in two-byte slots
module cpu_core_model (
  input  wire        aclk,      // Clock
  input  wire        mem_we,    // Write strobe
  input  wire [7:0]  mem_addr,  // Byte address
  input  wire [15:0] mem_wdata, // Write word
  output wire [15:0] mem_rdata  // Read word
);
  reg     [15:0] mem [0:127];
  integer        i;
  // Pattern fill, so an unwritten slot never reads as zero
  initial
  begin
    for (i = 0; i < 128; i = i + 1)
      mem[i] = 16'hc000 + i;
  end
  // Pushed words land at the word slot of the address
  always @(posedge aclk)
  begin
    if (mem_we)
      mem[mem_addr[7:1]] <= mem_wdata;
  end
  // Reads follow the address at once
  assign mem_rdata = mem[mem_addr[7:1]];
endmodule // cpu_core_model

/* irq_checker.sv */
`timescale 1ns/100ps
// Watches entry, return and bus answers of the controller
module irq_checker (
  input wire        aclk,          // Clock
  input wire        aresetn,       // Reset, active low
  input wire        boundary,      // Boundary pulse
  input wire        retire_return, // Return pulse
  input wire        s_axi_arvalid, // Read address valid
  input wire        s_axi_arready, // Read address ready
  input wire        s_axi_rvalid,  // Read data valid
  input wire        s_axi_rready,  // Read data ready
  input wire        s_axi_bvalid,  // Write response valid
  input wire        s_axi_bready,  // Write response ready
  input wire        irq_taken,     // Entry pulse
  input wire        mem_we,        // Memory write
  input wire        pc_load,       // PC load
  input wire [15:0] pc_value       // PC value
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_entry_vector: assert property (
    irq_taken |-> pc_load && pc_value == 16'h0010) else $error("bad vector");
  a_entry_push: assert property (
    irq_taken |-> mem_we) else $error("entry without push");
  a_entry_cause: assert property (
    irq_taken |-> $past(boundary)) else $error("entry without boundary");
  a_no_reentry: assert property (
    irq_taken |=> !irq_taken) else $error("entry while disabled");
  a_return_load: assert property (
    retire_return |-> ##2 pc_load) else $error("return without load");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid lost");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
endmodule // irq_checker
bind sixteen_bit_timer_interrupt_controller irq_checker chk_i (.*);

/* testbench.sv */
`timescale 1ns/100ps
`include "irq_timer_consts.vh"
module testbench;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0, rd_val;
  wire [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  reg         s_axi_rready = 1'b0, pin_a0_clock = 1'b0;
  reg         comparator_source = 1'b0;
  reg         pin_a5_level = 1'b0, pin_select_a5 = 1'b0;
  reg  [15:0] program_counter = 16'h0;
  reg  [7:0]  accumulator = 8'h0, flag_register = 8'h0;
  reg  [10:0] ops = 11'h0;
  reg  [3:0]  osc = 4'h0;
  reg  [1:0]  resp;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, mem_we, pc_load, af_restore, irq_taken;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  mem_addr;
  wire [15:0] mem_wdata, mem_rdata, pc_value, af_value;
  wire        boundary, retire_return, global_on, global_off;
  wire        store_to_timer, load_from_timer, push_af, pop_af;
  wire        timer2_event, timer3_event, pwm_generator_source;
  wire        pin_a4_clock = osc[2], fast_rc_oscillator = osc[1];
  wire        slow_rc_oscillator = osc[3];
  integer     err_count = 0, checks_done = 0, cyc = 0;
  integer     i, d, e;
  // Core pulses, one bit each
  assign {pwm_generator_source, timer3_event, timer2_event, pop_af, push_af,
    load_from_timer, store_to_timer, global_off, global_on, retire_return,
    boundary} = ops;
  sixteen_bit_timer_interrupt_controller DUT (.*);
  cpu_core_model core (.*);
  // Clock of 25 ns
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  // Slow source clocks for the timer, and the hang limit
  always @(posedge aclk)
  begin
    osc <= osc + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      conclude;
    end
  end
  task conclude;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] x);
    begin
      checks_done = checks_done + 1;
      if (s !== x)
      begin
        err_count = err_count + 1;
        $display("Error %s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  // Address and data offered together, each dropped when taken
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      rd_val = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  // One-cycle pulse; returns just after the edge that answers it
  task op(input [10:0] m);
    begin
      @(posedge aclk);
      ops <= m;
      @(posedge aclk);
      ops <= 11'h0;
      #1;
    end
  endtask
  task t_reset;
    begin
      for (i = 0; i < 9; i = i + 1)
      begin
        rd(i * 4);
        chk("reset value", rd_val, 32'h0);
      end
      rd(8'h3c);
      chk("unmapped rd", {resp, rd_val[29:0]}, 32'h80000000);
      wr(8'h3c, 32'h1);
      chk("unmapped wr", resp, 2'b10);
    end
  endtask
  task t_timer_io;
    begin
      op(11'h010);
      rd(`REG_COUNT);
      chk("store", rd_val, 32'h0000c000);
      op(11'h020);
      chk("load we", mem_we, 1'b1);
      chk("load word", mem_wdata, 16'hc000);
    end
  endtask
  task t_sources;
    reg [14:0] codes;
    begin
      codes = {3'h6, 3'h4, 3'h3, 3'h1, 3'h0};
      for (i = 0; i < 5; i = i + 1)
      begin
        wr(`REG_TIMER_MODE, {codes[i*3+:3], 5'h00});
        rd(`REG_COUNT);
        d = rd_val;
        tick(40);
        rd(`REG_COUNT);
        chk("source", rd_val > d, codes[i*3+:3] != 3'h0);
      end
      // Pin PA0 as clock: three pulses must give exactly three counts
      wr(`REG_TIMER_MODE, 32'he0);
      rd(`REG_COUNT);
      d = rd_val;
      for (i = 0; i < 3; i = i + 1)
      begin
        @(posedge aclk) pin_a0_clock <= 1'b1;
        tick(4);
        @(posedge aclk) pin_a0_clock <= 1'b0;
        tick(4);
      end
      rd(`REG_COUNT);
      chk("pin a0 source", rd_val - d, 32'h3);
    end
  endtask
  task t_prescale;
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        wr(`REG_TIMER_MODE, {3'h1, i[1:0], 3'h0});
        rd(`REG_COUNT);
        d = rd_val;
        e = cyc;
        tick(200);
        rd(`REG_COUNT);
        e = (cyc - e) >> (2 * i);
        d = rd_val - d;
        chk("prescale", d >= e - 1 && d <= e + 1, 1'b1);
      end
    end
  endtask
  // Tap bit kept when stopping, so no false tap transition appears
  task t_tap;
    reg [47:0] cases;
    begin
      cases = {8'h20, 8'h10, 8'h20, 8'h00, 8'h27, 8'h00};
      for (i = 0; i < 3; i = i + 1)
      begin
        wr(`REG_EDGE_SELECT, cases[i*16+:8]);
        wr(`REG_TIMER_MODE, cases[i*16+8+:8]);
        wr(`REG_REQ_FLAGS, 32'h3b);
        tick(520);
        wr(`REG_TIMER_MODE, cases[i*16+8+:3]);
        rd(`REG_REQ_FLAGS);
        chk("tap flag", rd_val[2], i != 0);
        wr(`REG_REQ_FLAGS, 32'h3b);
        rd(`REG_REQ_FLAGS);
        chk("flag clear", rd_val[2], 1'b0);
      end
    end
  endtask
  task t_lines;
    begin
      wr(`REG_REQ_FLAGS, 32'h0);
      wr(`REG_EDGE_SELECT, 32'h42);
      op(11'h700);
      @(posedge aclk) pin_a0_clock <= 1'b1;
      tick(8);
      rd(`REG_REQ_FLAGS);
      chk("pulse lines", rd_val, 32'h2a);
      @(posedge aclk) comparator_source <= 1'b1;
      tick(8);
      rd(`REG_REQ_FLAGS);
      chk("comparator", rd_val, 32'h3a);
      rd(`REG_STATUS);
      chk("status", rd_val[0], 1'b1);
      @(posedge aclk) pin_a0_clock <= 1'b0;
      tick(8);
      rd(`REG_REQ_FLAGS);
      chk("pin fall", rd_val, 32'h3b);
      // Same pin line fed from PA5; only its fall may set the flag
      wr(`REG_REQ_FLAGS, 32'h3e);
      @(posedge aclk) pin_select_a5 <= 1'b1;
      @(posedge aclk) pin_a5_level <= 1'b1;
      tick(8);
      rd(`REG_REQ_FLAGS);
      chk("pin a5 rise", rd_val, 32'h3a);
      @(posedge aclk) pin_a5_level <= 1'b0;
      tick(8);
      rd(`REG_REQ_FLAGS);
      chk("pin a5 fall", rd_val, 32'h3b);
    end
  endtask
  task t_entry;
    begin
      wr(`REG_STACK_PTR, 32'h40);
      wr(`REG_LINE_ENABLE, 32'h02);
      @(posedge aclk) program_counter <= 16'h1234;
      op(11'h001);
      chk("global off", irq_taken, 1'b0);
      op(11'h004);
      op(11'h001);
      chk("entry", irq_taken, 1'b1);
      chk("push", {mem_we, mem_addr, mem_wdata}, 25'h1401234);
      chk("vector", pc_value, `VECTOR_ADDR);
      rd(`REG_STACK_PTR);
      chk("sp up", rd_val, 32'h42);
      rd(`REG_GLOBAL_CTRL);
      chk("ge cleared", rd_val, 32'h0);
      rd(`REG_REQ_FLAGS);
      chk("pending", rd_val, 32'h3b);
      op(11'h002);
      tick(1);
      #1;
      chk("return", {pc_load, pc_value}, 17'h11234);
      rd(`REG_STACK_PTR);
      chk("sp down", rd_val, 32'h40);
      rd(`REG_GLOBAL_CTRL);
      chk("ge set", rd_val, 32'h1);
      op(11'h008);
      op(11'h001);
      chk("disabled", irq_taken, 1'b0);
      wr(`REG_LINE_ENABLE, 32'h0);
      op(11'h004);
      op(11'h001);
      chk("masked", irq_taken, 1'b0);
    end
  endtask
  task t_af;
    begin
      @(posedge aclk);
      accumulator <= 8'h5a;
      flag_register <= 8'ha5;
      op(11'h040);
      chk("push af", {mem_we, mem_wdata}, 17'h1a55a);
      op(11'h080);
      tick(1);
      #1;
      chk("pop af", {af_restore, af_value}, 17'h1a55a);
    end
  endtask
  // Main sequence
  initial
  begin
    tick(10);
    aresetn <= 1'b1;
    t_reset;
    t_timer_io;
    t_sources;
    t_prescale;
    t_tap;
    t_lines;
    t_entry;
    t_af;
    conclude;
  end
endmodule // testbench
